// ===== src/ssp_top.sv
// serial program port: entry, frame engine, pin driver
//
// Operation
// RULE1 - memory of 2048/4096 twelve-bit words plus config
// RULE2 - writes only accepted in programming mode
// RULE3 - erase clears whole memory and config words
// RULE4 - erased bits read as one
// RULE5 - programming only clears bits
// RULE6 - only clock pins used, data bit-serial
// RULE7 - pin low nine clocks enters programming mode
// RULE8 - programmer external-clock entry sequence
// RULE9 - programmer internal-clock entry sequence
// RULE10 - mode logic runs from 128 kHz clock
// RULE11 - entry resets device, ports become inputs
// RULE12 - one pin carries sync and data
// RULE13 - pin open-drain with pullup, idles high
// RULE14 - frame of 17 cycles, four clocks each
// RULE15 - internal clock period 7.81 microseconds
// RULE16 - first cycle is sync without pulse
// RULE17 - programmer drives four command cycles
// RULE18 - twelve data cycles, direction by command
// RULE19 - read returns word on same pin
// RULE20 - clock two pulse, data clocks three-four
// RULE21 - decode the nine command codes
// RULE22 - code 1111 does nothing
// RULE23 - pointer starts at top, increments wrap
// RULE24 - bits sent most significant first
`timescale 1ns/1ps
module ssp_top import ssp_pkg::*; #(
    parameter int                    DEPTH    = SSP_DEPTH,
    parameter int                    TICK_CYC = SSP_TICK_CYC,
    parameter logic [SSP_WORD_W-1:0] ID_WORD  = 12'h5A3 // arbitrary value
) (
    input  wire logic sys_clk,
    input  wire logic resetn,
    input  wire logic pgm_pin_i,
    output logic      pgm_pin_o,
    output logic      pgm_pin_oe_n,
    input  wire logic clk_in_pin_i,
    input  wire logic app_clk_tick_i,
    input  wire logic vpp_present_i,
    output logic      dev_reset_o,
    output logic      prog_mode_o
);
    localparam int            AW       = $clog2(DEPTH) + 1;
    localparam logic [AW-1:0] ADDR_TOP = {AW{1'b1}};
    localparam logic [15:0]   TICK_MAX = 16'(TICK_CYC - 1);
    generate
        if (TICK_CYC < 9 || TICK_CYC > 65535) begin : g_bad_tick
            $error("ssp_top: tick count out of range");
        end
    endgenerate
    // ==========================================
    // submodules
    ssp_flash_if #(.AW(AW), .W(SSP_WORD_W)) fl ();
    logic mode_q;
    ssp_entry u_entry (
        .sys_clk      (sys_clk),
        .resetn       (resetn),
        .pin_level    (pgm_pin_i),
        .clk_in_level (clk_in_pin_i),
        .int_tick     (app_clk_tick_i),
        .vpp_present  (vpp_present_i),
        .mode_q       (mode_q),
        .dev_reset_q  (dev_reset_o)
    );
    ssp_flash #(.DEPTH(DEPTH)) u_flash (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .f       (fl.mem)
    );
    // ==========================================
    // frame engine state
    ssp_frame_t            fr_q;
    ssp_frame_t            fr_d;
    logic [15:0]           tick_cnt_q;
    logic [15:0]           tick_cnt_d;
    logic                  tick_q;
    logic                  tick_d;
    logic [1:0]            phase_q;
    logic [1:0]            phase_d;
    logic [4:0]            cyc_q;
    logic [4:0]            cyc_d;
    logic [3:0]            cmd_sh_q;
    logic [3:0]            cmd_sh_d;
    ssp_cmd_t              cmd_q;
    ssp_cmd_t              cmd_d;
    logic [3:0]            cmd_full;
    logic [SSP_WORD_W-1:0] data_sh_q;
    logic [SSP_WORD_W-1:0] data_sh_d;
    logic [SSP_WORD_W-1:0] out_sh_q;
    logic [SSP_WORD_W-1:0] out_sh_d;
    logic [SSP_WORD_W-1:0] latch_q;
    logic [SSP_WORD_W-1:0] latch_d;
    logic                  rd_act_q;
    logic                  rd_act_d;
    logic [AW-1:0]         addr_q;
    logic [AW-1:0]         addr_d;
    logic                  erase_q;
    logic                  erase_d;
    logic                  prog_word_q;
    logic                  prog_word_d;
    logic                  prog_ext_q;
    logic                  prog_ext_d;
    logic                  oe_n_q;
    logic                  oe_n_d;
    logic                  pull_low;
    assign cmd_full = {cmd_sh_q[2:0], pgm_pin_i};
    // ==========================================
    // next-state logic
    always_comb begin
        fr_d        = fr_q;
        tick_cnt_d  = tick_cnt_q;
        tick_d      = 1'b0;
        phase_d     = phase_q;
        cyc_d       = cyc_q;
        cmd_sh_d    = cmd_sh_q;
        cmd_d       = cmd_q;
        data_sh_d   = data_sh_q;
        out_sh_d    = out_sh_q;
        latch_d     = latch_q;
        rd_act_d    = rd_act_q;
        addr_d      = addr_q;
        erase_d     = 1'b0;
        prog_word_d = 1'b0;
        prog_ext_d  = 1'b0;
        case (fr_q)
            SSP_FR_IDLE: begin
                tick_cnt_d = 16'h0000;
                phase_d    = 2'h0;
                cyc_d      = SSP_CYC_SYNC;
                rd_act_d   = 1'b0;
                cmd_d      = SSP_CMD_NOP;
                addr_d     = ADDR_TOP; //RULE23
                if (mode_q) begin
                    fr_d = SSP_FR_RUN;
                end
            end
            SSP_FR_RUN: begin
                if (!mode_q) begin
                    fr_d = SSP_FR_IDLE;
                end else begin
                    if (tick_cnt_q == TICK_MAX) begin //RULE10 RULE15
                        tick_cnt_d = 16'h0000;
                        tick_d     = 1'b1;
                    end else begin
                        tick_cnt_d = tick_cnt_q + 16'h0001;
                    end
                    if (tick_q && phase_q == SSP_PH_DATA) begin //RULE20
                        if (cyc_q != SSP_CYC_SYNC && cyc_q <= SSP_CYC_CMD0) begin
                            cmd_sh_d = cmd_full; //RULE17 RULE24
                        end
                        if (cyc_q == SSP_CYC_CMD0) begin
                            cmd_d    = SSP_CMD_NOP;
                            rd_act_d = 1'b0;
                            out_sh_d = SSP_ERASED;
                            case (cmd_full) //RULE21
                                SSP_CMD_ERASE, SSP_CMD_PROG_EXT, SSP_CMD_LOAD, SSP_CMD_PROG, SSP_CMD_INC: begin
                                    cmd_d = ssp_cmd_t'(cmd_full);
                                end
                                SSP_CMD_RD_ID: begin
                                    rd_act_d = 1'b1; //RULE18
                                    out_sh_d = ID_WORD;
                                end
                                SSP_CMD_RD_EXT: begin
                                    rd_act_d = 1'b1;
                                    out_sh_d = fl.ext_rdata;
                                end
                                SSP_CMD_RD_DATA: begin
                                    rd_act_d = 1'b1; //RULE19
                                    out_sh_d = fl.rdata;
                                end
                                default: begin
                                    cmd_d = SSP_CMD_NOP; //RULE22
                                end
                            endcase
                        end
                        if (cyc_q >= SSP_CYC_DATA11) begin
                            data_sh_d = {data_sh_q[SSP_WORD_W-2:0], pgm_pin_i}; //RULE24
                        end
                    end
                    if (tick_q) begin
                        if (phase_q == SSP_PH_LAST) begin
                            phase_d = 2'h0;
                            if (cyc_q >= SSP_CYC_DATA11) begin
                                out_sh_d = {out_sh_q[SSP_WORD_W-2:0], 1'b1};
                            end
                            if (cyc_q == SSP_CYC_LAST) begin //RULE14
                                cyc_d    = SSP_CYC_SYNC;
                                rd_act_d = 1'b0;
                                cmd_d    = SSP_CMD_NOP;
                                case (cmd_q)
                                    SSP_CMD_ERASE:    erase_d     = 1'b1; //RULE3
                                    SSP_CMD_LOAD:     latch_d     = data_sh_q;
                                    SSP_CMD_PROG:     prog_word_d = 1'b1;
                                    SSP_CMD_PROG_EXT: prog_ext_d  = 1'b1;
                                    SSP_CMD_INC:      addr_d      = addr_q + AW'(1); //RULE23
                                    default:          latch_d     = latch_q;
                                endcase
                            end else begin
                                cyc_d = cyc_q + 5'h01;
                            end
                        end else begin
                            phase_d = phase_q + 2'h1;
                        end
                    end
                end
            end
            default: begin
                fr_d = SSP_FR_IDLE;
            end
        endcase
        // pulse in clock two, read data in clocks three-four
        pull_low = (fr_d == SSP_FR_RUN) && (
                   (phase_d == SSP_PH_PULSE && cyc_d != SSP_CYC_SYNC) || //RULE16 RULE20
                   (phase_d >= SSP_PH_DATA && rd_act_d && cyc_d >= SSP_CYC_DATA11 && !out_sh_d[SSP_WORD_W-1]));
        oe_n_d   = !pull_low; //RULE12 RULE13
    end
    // ==========================================
    // registers
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            fr_q        <= SSP_FR_IDLE;
            tick_cnt_q  <= 16'h0000;
            tick_q      <= 1'b0;
            phase_q     <= 2'h0;
            cyc_q       <= 5'h00;
            cmd_sh_q    <= 4'hF;
            cmd_q       <= SSP_CMD_NOP;
            data_sh_q   <= 12'hFFF;
            out_sh_q    <= 12'hFFF;
            latch_q     <= 12'hFFF;
            rd_act_q    <= 1'b0;
            addr_q      <= '1;
            erase_q     <= 1'b0;
            prog_word_q <= 1'b0;
            prog_ext_q  <= 1'b0;
            oe_n_q      <= 1'b1;
            pgm_pin_o   <= 1'b0;
            prog_mode_o <= 1'b0;
        end else begin
            fr_q        <= fr_d;
            tick_cnt_q  <= tick_cnt_d;
            tick_q      <= tick_d;
            phase_q     <= phase_d;
            cyc_q       <= cyc_d;
            cmd_sh_q    <= cmd_sh_d;
            cmd_q       <= cmd_d;
            data_sh_q   <= data_sh_d;
            out_sh_q    <= out_sh_d;
            latch_q     <= latch_d;
            rd_act_q    <= rd_act_d;
            addr_q      <= addr_d;
            erase_q     <= erase_d;
            prog_word_q <= prog_word_d;
            prog_ext_q  <= prog_ext_d;
            oe_n_q      <= oe_n_d;
            pgm_pin_o   <= 1'b0; //RULE6 RULE13
            prog_mode_o <= mode_q;
        end
    end
    assign pgm_pin_oe_n = oe_n_q;
    assign fl.prog_mode = mode_q; //RULE2
    assign fl.erase     = erase_q;
    assign fl.prog_word = prog_word_q;
    assign fl.prog_ext  = prog_ext_q;
    assign fl.addr      = addr_q;
    assign fl.wdata     = latch_q;
    // ==========================================
    // checks
    a_sync_no_pulse: assert property (@(posedge sys_clk) disable iff (!resetn) //RULE16
        fr_q == SSP_FR_RUN && cyc_q == SSP_CYC_SYNC |-> oe_n_q)
        else $error("pin driven in sync cycle");
    a_pulse_clock_two: assert property (@(posedge sys_clk) disable iff (!resetn) //RULE20
        fr_q == SSP_FR_RUN && phase_q == SSP_PH_PULSE && cyc_q != SSP_CYC_SYNC |-> !oe_n_q)
        else $error("missing sync pulse");
    a_first_clock_free: assert property (@(posedge sys_clk) disable iff (!resetn) //RULE13
        phase_q == 2'h0 |-> oe_n_q)
        else $error("pin driven in clock one");
    a_frame_wraps: assert property (@(posedge sys_clk) disable iff (!resetn) //RULE14
        mode_q && tick_q && phase_q == SSP_PH_LAST && cyc_q == SSP_CYC_LAST |=> cyc_q == SSP_CYC_SYNC && phase_q == 2'h0)
        else $error("frame length wrong");
    a_tick_spacing: assert property (@(posedge sys_clk) disable iff (!resetn) //RULE15
        tick_q |=> !tick_q [*8])
        else $error("internal clock too fast");
    a_reset_held: assert property (@(posedge sys_clk) disable iff (!resetn) //RULE11
        mode_q |-> dev_reset_o && $past(dev_reset_o))
        else $error("device not held in reset");
    a_read_msb_out: assert property (@(posedge sys_clk) disable iff (!resetn) //RULE19
        fr_q == SSP_FR_RUN && rd_act_q && phase_q >= SSP_PH_DATA && cyc_q >= SSP_CYC_DATA11
        |-> oe_n_q == out_sh_q[SSP_WORD_W-1])
        else $error("read bit not on pin");
    a_nop_idle: assert property (@(posedge sys_clk) disable iff (!resetn) //RULE22
        cmd_q == SSP_CMD_NOP && tick_q && phase_q == SSP_PH_LAST && cyc_q == SSP_CYC_LAST
        |=> !erase_q && !prog_word_q && !prog_ext_q && addr_q == $past(addr_q))
        else $error("no-op had an effect");
    a_addr_wraps: assert property (@(posedge sys_clk) disable iff (!resetn) //RULE23
        mode_q && cmd_q == SSP_CMD_INC && addr_q == ADDR_TOP && tick_q && phase_q == SSP_PH_LAST
        && cyc_q == SSP_CYC_LAST |=> addr_q == '0)
        else $error("pointer did not wrap");
    a_write_gated: assert property (@(posedge sys_clk) disable iff (!resetn) //RULE2
        prog_word_q || erase_q || prog_ext_q |-> mode_q)
        else $error("write outside programming mode");
    c_entry: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(mode_q));
    c_read: cover property (@(posedge sys_clk) disable iff (!resetn) rd_act_q && cyc_q == SSP_CYC_LAST);
    c_erase: cover property (@(posedge sys_clk) disable iff (!resetn) erase_q);
endmodule

// ===== src/ssp_pkg.sv
// constants and types of the serial program port
package ssp_pkg;
    // ==========================================
    // memory shape
    localparam int          SSP_DEPTH      = 4096;
    localparam int          SSP_DEPTH_ALT  = 2048;
    localparam int          SSP_WORD_W     = 12;
    localparam logic [11:0] SSP_ERASED     = 12'hFFF;
    // ==========================================
    // timing
    localparam int          SSP_SYS_PERIOD_NS  = 25;
    localparam int          SSP_ICLK_PERIOD_NS = 7810;
    localparam int          SSP_TICK_CYC       = SSP_ICLK_PERIOD_NS / SSP_SYS_PERIOD_NS;
    localparam logic [3:0]  SSP_ENTRY_CLKS     = 4'h9;
    // ==========================================
    // frame layout
    localparam logic [1:0]  SSP_PH_PULSE   = 2'h1;
    localparam logic [1:0]  SSP_PH_DATA    = 2'h2;
    localparam logic [1:0]  SSP_PH_LAST    = 2'h3;
    localparam logic [4:0]  SSP_CYC_SYNC   = 5'h00;
    localparam logic [4:0]  SSP_CYC_CMD0   = 5'h04;
    localparam logic [4:0]  SSP_CYC_DATA11 = 5'h05;
    localparam logic [4:0]  SSP_CYC_LAST   = 5'h10;
    // ==========================================
    // command codes
    typedef enum logic [3:0] {
        SSP_CMD_ERASE    = 4'h0,
        SSP_CMD_RD_ID    = 4'h1,
        SSP_CMD_RD_EXT   = 4'h2,
        SSP_CMD_PROG_EXT = 4'h3,
        SSP_CMD_LOAD     = 4'h4,
        SSP_CMD_PROG     = 4'h5,
        SSP_CMD_RD_DATA  = 4'h6,
        SSP_CMD_INC      = 4'h7,
        SSP_CMD_NOP      = 4'hF
    } ssp_cmd_t;
    // ==========================================
    // state machines
    typedef enum logic [1:0] {
        SSP_EN_OFF    = 2'b00,
        SSP_EN_ARMED  = 2'b01,
        SSP_EN_ACTIVE = 2'b10
    } ssp_entry_t;
    typedef enum logic {
        SSP_FR_IDLE = 1'b0,
        SSP_FR_RUN  = 1'b1
    } ssp_frame_t;
endpackage

// ===== src/ssp_flash_if.sv
// link between frame logic and the program memory array
`timescale 1ns/1ps
interface ssp_flash_if #(parameter int AW = 13, parameter int W = 12);
    logic          prog_mode;
    logic          erase;
    logic          prog_word;
    logic          prog_ext;
    logic [AW-1:0] addr;
    logic [W-1:0]  wdata;
    logic [W-1:0]  rdata;
    logic [W-1:0]  ext_rdata;
    modport ctl (output prog_mode, erase, prog_word, prog_ext, addr, wdata, input rdata, ext_rdata);
    modport mem (input prog_mode, erase, prog_word, prog_ext, addr, wdata, output rdata, ext_rdata);
endinterface

// ===== src/ssp_flash.sv
// flip-flop model of the nonvolatile program memory and config words
`timescale 1ns/1ps
module ssp_flash import ssp_pkg::*; #(
    parameter int DEPTH = SSP_DEPTH
) (
    input  wire logic sys_clk,
    input  wire logic resetn,
    ssp_flash_if.mem  f
);
    localparam int AW = $clog2(DEPTH) + 1;
    generate
        if (DEPTH != SSP_DEPTH && DEPTH != SSP_DEPTH_ALT) begin : g_bad_depth
            $error("ssp_flash: unsupported depth");
        end
    endgenerate
    // ==========================================
    // storage, index DEPTH is the main config word
    logic [SSP_WORD_W-1:0] mem_q [DEPTH+1];
    logic [SSP_WORD_W-1:0] mem_d [DEPTH+1];
    logic [SSP_WORD_W-1:0] ext_q;
    logic [SSP_WORD_W-1:0] ext_d;
    logic                  top_sel;
    assign top_sel = (f.addr == {AW{1'b1}});
    always_comb begin
        mem_d = mem_q;
        ext_d = ext_q;
        if (f.prog_mode && f.erase) begin //RULE3
            for (int i = 0; i <= DEPTH; i++) begin
                mem_d[i] = SSP_ERASED; //RULE4
            end
            ext_d = SSP_ERASED;
        end else if (f.prog_mode && f.prog_word) begin //RULE2
            if (top_sel) begin
                mem_d[DEPTH] = mem_q[DEPTH] & f.wdata; //RULE5
            end else if (int'(f.addr) < DEPTH) begin
                mem_d[f.addr] = mem_q[f.addr] & f.wdata; //RULE5
            end
        end else if (f.prog_mode && f.prog_ext) begin
            ext_d = ext_q & f.wdata; //RULE5
        end
    end
    always_ff @(posedge sys_clk) begin
        mem_q <= mem_d; //RULE1
        ext_q <= ext_d;
    end
    assign f.rdata     = top_sel ? mem_q[DEPTH] : (int'(f.addr) < DEPTH) ? mem_q[f.addr] : SSP_ERASED;
    assign f.ext_rdata = ext_q;
    // ==========================================
    // checks
    a_erase_all_ones: assert property (@(posedge sys_clk) disable iff (!resetn) //RULE4
        f.prog_mode && f.erase |=> f.ext_rdata == SSP_ERASED && mem_q[0] == SSP_ERASED)
        else $error("erase did not leave ones");
    a_prog_only_clears: assert property (@(posedge sys_clk) disable iff (!resetn) //RULE5
        f.prog_mode && f.prog_ext && !f.erase |=> f.ext_rdata == ($past(f.ext_rdata) & $past(f.wdata)))
        else $error("programming set a bit");
endmodule

// ===== src/ssp_entry.sv
// programming mode entry detector and device reset hold
`timescale 1ns/1ps
module ssp_entry import ssp_pkg::*; (
    input  wire logic sys_clk,
    input  wire logic resetn,
    input  wire logic pin_level,
    input  wire logic clk_in_level,
    input  wire logic int_tick,
    input  wire logic vpp_present,
    output logic      mode_q,
    output logic      dev_reset_q
);
    ssp_entry_t st_q;
    ssp_entry_t st_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic       clk_prev_q;
    logic       ev;
    // ==========================================
    // low-time counting on pin clock or internal clock
    assign ev = (clk_in_level && !clk_prev_q) || int_tick; //RULE8 RULE9
    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        case (st_q)
            SSP_EN_OFF: begin
                if (pin_level) begin
                    cnt_d = 4'h0;
                end else if (ev) begin
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_d == SSP_ENTRY_CLKS) begin //RULE7
                        st_d = SSP_EN_ARMED;
                    end
                end
            end
            SSP_EN_ARMED: begin
                if (pin_level && vpp_present) begin //RULE8
                    st_d = SSP_EN_ACTIVE;
                end
            end
            SSP_EN_ACTIVE: begin
                if (!vpp_present) begin
                    st_d  = SSP_EN_OFF;
                    cnt_d = 4'h0;
                end
            end
            default: begin
                st_d  = SSP_EN_OFF;
                cnt_d = 4'h0;
            end
        endcase
    end
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_q        <= SSP_EN_OFF;
            cnt_q       <= 4'h0;
            clk_prev_q  <= 1'b0;
            mode_q      <= 1'b0;
            dev_reset_q <= 1'b0;
        end else begin
            st_q        <= st_d;
            cnt_q       <= cnt_d;
            clk_prev_q  <= clk_in_level;
            mode_q      <= (st_d == SSP_EN_ACTIVE); //RULE10
            dev_reset_q <= (st_d != SSP_EN_OFF); //RULE11
        end
    end
endmodule

// ===== testbench/ssp_prog_model.sv
// programmer unit model on the far side of the pin
`timescale 1ns/1ps
module ssp_prog_model #(
    parameter int TICK_CYC = 12
) (
    input  wire logic sys_clk,
    input  wire logic pin,
    output logic      pin_low,
    output logic      clk_in,
    output logic      app_tick,
    output logic      vpp
);
    logic pin_prev = 1'b1;
    int   hi_cnt   = 0;
    initial {pin_low, clk_in, app_tick, vpp} = 4'h0;
    always @(posedge sys_clk) begin
        pin_prev <= pin;
        hi_cnt   <= pin ? hi_cnt + 1 : 0;
    end
    // ==========
    // entry: pin low over n clocks, release, vpp
    task automatic enter(input int n, input bit ext);
        {vpp, clk_in} <= 2'b00;
        repeat (4) @(posedge sys_clk);
        pin_low <= 1'b1;
        repeat (n) begin
            repeat (2) @(posedge sys_clk);
            {clk_in, app_tick} <= {ext, !ext};
            @(posedge sys_clk);
            {clk_in, app_tick} <= 2'b00;
        end
        repeat (3) @(posedge sys_clk);
        pin_low <= 1'b0;
        @(posedge sys_clk);
        vpp <= 1'b1;
        repeat (4) @(posedge sys_clk);
    endtask
    // ==========
    // frame: align on first pulse after sync
    task automatic frame(input logic [3:0] cmd, input logic [11:0] wr, input bit rd_en, output logic [11:0] rd);
        logic [15:0] bits;
        bits = {cmd, wr};
        rd   = 12'h000;
        for (int i = 0; i < 16; i++) begin
            do @(posedge sys_clk); while (!(pin_prev && !pin && (i > 0 || hi_cnt > 4 * TICK_CYC)));
            repeat (TICK_CYC + TICK_CYC / 2) @(posedge sys_clk);
            if (i < 4 || !rd_en) pin_low <= !bits[15 - i];
            repeat (TICK_CYC) @(posedge sys_clk);
            if (i >= 4) rd[15 - i] = pin;
            pin_low <= 1'b0;
        end
    endtask
endmodule

// ===== testbench/serial_program_port_tb_top.sv
// self-checking bench of the serial program port
`timescale 1ns/1ps
module serial_program_port_tb_top;
    import ssp_pkg::*;
    localparam int          TICK = 12;
    localparam logic [11:0] ID   = 12'h3C6; // arbitrary value
    logic        sys_clk = 1'b0;
    logic        resetn  = 1'b0;
    logic        pin_o, pin_oe_n, pin_low, clk_in, app_tick, vpp, dev_reset, prog_mode;
    logic [11:0] rd;
    int          errors = 0, total_checks = 0, cycles = 0, t0;
    wire         pin = (pin_oe_n | pin_o) & ~pin_low;
    always #12.5 sys_clk = ~sys_clk;
    ssp_top #(.DEPTH(4096), .TICK_CYC(TICK), .ID_WORD(ID)) i_ssp_top (
        .sys_clk(sys_clk), .resetn(resetn), .pgm_pin_i(pin), .pgm_pin_o(pin_o), .pgm_pin_oe_n(pin_oe_n),
        .clk_in_pin_i(clk_in), .app_clk_tick_i(app_tick), .vpp_present_i(vpp), .dev_reset_o(dev_reset),
        .prog_mode_o(prog_mode));
    ssp_prog_model #(.TICK_CYC(TICK)) i_ssp_prog_model (
        .sys_clk(sys_clk), .pin(pin), .pin_low(pin_low), .clk_in(clk_in), .app_tick(app_tick), .vpp(vpp));
    task automatic end_sim(input int fail);
        errors += fail;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        errors += int'(got !== exp);
        if (got !== exp) $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    endtask
    task automatic fr(input logic [3:0] c, input logic [11:0] w, input bit r);
        i_ssp_prog_model.frame(c, w, r, rd);
    endtask
    task automatic t_entry();
        i_ssp_prog_model.enter(8, 1'b1);
        chk({dev_reset, 10'h000, prog_mode}, 12'h000);
        i_ssp_prog_model.enter(9, 1'b0);
        chk({dev_reset, 10'h000, prog_mode}, 12'h801);
    endtask
    task automatic t_prog();
        fr(SSP_CMD_ERASE, 12'h000, 1'b0);
        fr(SSP_CMD_RD_DATA, 12'h000, 1'b1);
        chk(rd, SSP_ERASED);
        fr(SSP_CMD_LOAD, 12'hA5C, 1'b0);
        fr(SSP_CMD_PROG_EXT, 12'h000, 1'b0);
        t0 = cycles;
        fr(SSP_CMD_RD_EXT, 12'h000, 1'b1);
        chk(12'(cycles - t0), 12'h330);
        chk(rd, 12'hA5C);
        fr(SSP_CMD_LOAD, 12'h3F0, 1'b0);
        fr(SSP_CMD_PROG_EXT, 12'h000, 1'b0);
        fr(SSP_CMD_RD_EXT, 12'h000, 1'b1);
        chk(rd, 12'h250);
        fr(SSP_CMD_INC, 12'h000, 1'b0);
        fr(SSP_CMD_LOAD, 12'h123, 1'b0);
        fr(SSP_CMD_PROG, 12'h000, 1'b0);
        fr(SSP_CMD_RD_DATA, 12'h000, 1'b1);
        chk(rd, 12'h123);
        fr(4'h8, 12'h000, 1'b0);
        fr(SSP_CMD_NOP, 12'h000, 1'b0);
        fr(SSP_CMD_RD_DATA, 12'h000, 1'b1);
        chk(rd, 12'h123);
        fr(SSP_CMD_RD_ID, 12'h000, 1'b1);
        chk(rd, ID);
    endtask
    task automatic t_reentry();
        i_ssp_prog_model.enter(9, 1'b1);
        chk({dev_reset, 10'h000, prog_mode}, 12'h801);
        fr(SSP_CMD_RD_DATA, 12'h000, 1'b1);
        chk(rd, SSP_ERASED);
        fr(SSP_CMD_INC, 12'h000, 1'b0);
        fr(SSP_CMD_RD_DATA, 12'h000, 1'b1);
        chk(rd, 12'h123);
    endtask
    initial begin
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        t_entry();
        t_prog();
        t_reentry();
        end_sim(0);
    end
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) end_sim(1);
    end
endmodule
